/* pkg/ect_consts.svh */
// Register indices, field positions and reset values of the event capture timer
`ifndef ECT_CONSTS_SVH
`define ECT_CONSTS_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define ECT_IDX_CTRL_A 4'h0
`define ECT_IDX_CTRL_B 4'h1
`define ECT_IDX_EVENT_INPUT_CONTROL 4'h4
`define ECT_IDX_INTEN 4'h5
`define ECT_IDX_FLAGS 4'h6
`define ECT_IDX_STATUS 4'h7
`define ECT_IDX_HALTCTL 4'h8
`define ECT_IDX_STAGING 4'h9
`define ECT_IDX_COUNT_LO 4'ha
`define ECT_IDX_COUNT_HI 4'hb
`define ECT_IDX_CMP_LO 4'hc
`define ECT_IDX_CMP_HI 4'hd

// ==========================================================
// Field positions
`define ECT_POS_ENABLE 0
`define ECT_POS_CLKSEL 1
`define ECT_POS_MODE 0
`define ECT_POS_EDGE 4
`define ECT_POS_EVLATCH_EN 0
`define ECT_POS_LATCH_IE 0
`define ECT_POS_LATCH_FLAG 0
`define ECT_POS_RUN 0
`define ECT_POS_HALT_BYPASS 0

// ==========================================================
// Clock select codes
`define ECT_CLKSEL_FULL 2'h0
`define ECT_CLKSEL_HALF 2'h1

// ==========================================================
// Reset values
`define ECT_RST_BYTE 8'h00
`define ECT_RST_WORD 16'h0000

`endif

/* pkg/ect_pkg.sv */
// Types of the event capture timer
package ect_pkg;

  // ==========================================================
  // Count modes
  typedef enum logic [2:0] {
    ECT_MODE_PERIODIC = 3'b000,
    ECT_MODE_TIMEOUT = 3'b001,
    ECT_MODE_LATCH_FLAG_EVENT = 3'b010,
    ECT_MODE_FREQ = 3'b011,
    ECT_MODE_PULSE_WIDTH = 3'b100,
    ECT_MODE_FREQ_PW = 3'b101,
    ECT_MODE_SINGLE_SHOT = 3'b110,
    ECT_MODE_PWM8 = 3'b111
  } ect_mode_t;

  // ==========================================================
  // Phases of the combined frequency and pulse width measurement
  typedef enum logic [1:0] {
    ECT_FP_WAIT_INIT = 2'b00,
    ECT_FP_WAIT_CAPTURE = 2'b01,
    ECT_FP_WAIT_STOP = 2'b10
  } ect_fp_t;

  // ==========================================================
  // Whole state of the timer
  typedef struct packed {
    logic enable;
    logic [1:0] clk_sel;
    ect_mode_t count_mode_field;
    logic edge_sel;
    logic event_latch_input_enable;
    logic latch_ie;
    logic latch_flag;
    logic run;
    logic halt_bypass;
    logic [7:0] staging;
    logic [15:0] timer_count;
    logic [15:0] compare_latch_value;
    logic ev_prev;
    ect_fp_t fp_phase;
    logic div;
    logic pready;
    logic pslverr;
    logic [7:0] prdata;
    logic irq;
  } ect_state_t;

endpackage

/* rtl/ect_timer.sv */
// Event capture timer: 16-bit counter with event-driven modes behind an APB slave
`timescale 1ns/1ns
`include "ect_consts.svh"
`default_nettype none

module ect_timer
  import ect_pkg::*;
(
  input wire logic CORE_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [3:0] PSTRB_IN,
  input wire logic EVENT_IN,
  input wire logic DBG_HALT_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  output logic IRQ_OUT,
  output logic RUN_OUT
);

  // ==========================================================
  // Helpers
  function automatic logic pick_edge(input logic rise, input logic fall, input logic pol);
    pick_edge = pol ? fall : rise;
  endfunction

  function automatic logic is_capture_mode(input ect_mode_t m);
    is_capture_mode = (m == ECT_MODE_LATCH_FLAG_EVENT) || (m == ECT_MODE_FREQ) ||
                      (m == ECT_MODE_PULSE_WIDTH) || (m == ECT_MODE_FREQ_PW);
  endfunction

  // ==========================================================
  // State
  ect_state_t q;
  ect_state_t d;

  logic halted;
  logic rise;
  logic fall;
  logic ev_live;
  logic tick;
  logic at_top;
  logic sel_edge;
  logic opp_edge;
  logic setup_acc;
  logic acc_done;
  logic wr;
  logic rd;
  logic mapped;
  logic [3:0] idx;
  logic [7:0] wbyte;
  logic byte_wr;

  assign halted = DBG_HALT_IN & ~q.halt_bypass;
  assign rise = EVENT_IN & ~q.ev_prev;
  assign fall = ~EVENT_IN & q.ev_prev;
  assign ev_live = q.enable & q.event_latch_input_enable & ~halted;
  assign tick = q.enable & ~halted &
                ((q.clk_sel == `ECT_CLKSEL_FULL) | ((q.clk_sel == `ECT_CLKSEL_HALF) & q.div));
  assign at_top = q.timer_count == q.compare_latch_value;
  assign sel_edge = ev_live & pick_edge(rise, fall, q.edge_sel);
  assign opp_edge = ev_live & pick_edge(rise, fall, ~q.edge_sel);

  assign idx = PADDR_IN[5:2];
  assign mapped = (PADDR_IN[7:6] == 2'h0) && (PADDR_IN[1:0] == 2'h0) &&
                  ((idx <= `ECT_IDX_CTRL_B) || ((idx >= `ECT_IDX_EVENT_INPUT_CONTROL) && (idx <= `ECT_IDX_CMP_HI)));
  assign setup_acc = PSEL_IN & PENABLE_IN & ~q.pready;
  assign acc_done = PSEL_IN & PENABLE_IN & q.pready;
  assign wr = acc_done & PWRITE_IN & mapped;
  assign rd = acc_done & ~PWRITE_IN & mapped;
  assign byte_wr = wr & PSTRB_IN[0];
  assign wbyte = PWDATA_IN[7:0];

  // ==========================================================
  // Next state
  always_comb begin
    logic flag_set;
    logic flag_clr;
    flag_set = 1'b0;
    flag_clr = 1'b0;
    d = q;
    d.ev_prev = EVENT_IN;
    d.div = q.enable ? ~q.div : 1'b0;

    // Counting and event reactions per mode
    case (q.count_mode_field)
      ECT_MODE_PERIODIC: begin
        d.run = q.enable;
        if (tick) begin
          if (at_top) begin
            d.timer_count = 16'h0000;
            flag_set = 1'b1;
          end else begin
            d.timer_count = q.timer_count + 16'h0001;
          end
        end
      end
      ECT_MODE_TIMEOUT: begin
        if (sel_edge) begin
          d.run = 1'b1;
          d.timer_count = 16'h0000;
        end else if (opp_edge) begin
          d.run = 1'b0;
        end else if (tick && q.run) begin
          if (at_top) begin
            d.timer_count = 16'h0000;
            flag_set = 1'b1;
          end else begin
            d.timer_count = q.timer_count + 16'h0001;
          end
        end
      end
      ECT_MODE_LATCH_FLAG_EVENT: begin
        d.run = q.enable;
        if (tick) begin
          d.timer_count = q.timer_count + 16'h0001;
        end
        if (sel_edge) begin
          d.compare_latch_value = q.timer_count;
          flag_set = 1'b1;
        end
      end
      ECT_MODE_FREQ: begin
        d.run = q.enable;
        if (sel_edge) begin
          d.compare_latch_value = q.timer_count;
          d.timer_count = 16'h0000;
          flag_set = 1'b1;
        end else if (tick) begin
          d.timer_count = q.timer_count + 16'h0001;
        end
      end
      ECT_MODE_PULSE_WIDTH: begin
        d.run = q.enable;
        if (sel_edge) begin
          d.timer_count = 16'h0000;
        end else begin
          if (tick) begin
            d.timer_count = q.timer_count + 16'h0001;
          end
          if (opp_edge) begin
            d.compare_latch_value = q.timer_count;
            flag_set = 1'b1;
          end
        end
      end
      ECT_MODE_FREQ_PW: begin
        if (tick && q.run) begin
          d.timer_count = q.timer_count + 16'h0001;
        end
        case (q.fp_phase)
          ECT_FP_WAIT_INIT: begin
            if (sel_edge) begin
              d.timer_count = 16'h0000;
              d.run = 1'b1;
              d.fp_phase = ECT_FP_WAIT_CAPTURE;
            end
          end
          ECT_FP_WAIT_CAPTURE: begin
            if (opp_edge) begin
              d.compare_latch_value = q.timer_count;
              d.fp_phase = ECT_FP_WAIT_STOP;
            end
          end
          ECT_FP_WAIT_STOP: begin
            if (sel_edge) begin
              d.run = 1'b0;
              d.timer_count = q.timer_count;
              flag_set = 1'b1;
              d.fp_phase = ECT_FP_WAIT_INIT;
            end
          end
          default: begin
            d.fp_phase = ECT_FP_WAIT_INIT;
          end
        endcase
      end
      ECT_MODE_SINGLE_SHOT: begin
        // A retrigger while running is ignored so the shot length stays TOP
        if (ev_live && !q.run && (rise || (q.edge_sel && fall))) begin
          d.run = 1'b1;
          d.timer_count = 16'h0000;
        end else if (tick && q.run) begin
          if (at_top) begin
            d.run = 1'b0;
            d.timer_count = 16'h0000;
            flag_set = 1'b1;
          end else begin
            d.timer_count = q.timer_count + 16'h0001;
          end
        end
      end
      ECT_MODE_PWM8: begin
        d.run = q.enable;
        if (tick) begin
          d.timer_count[15:8] = 8'h00;
          if (q.timer_count[7:0] == q.compare_latch_value[7:0]) begin
            d.timer_count[7:0] = 8'h00;
          end else begin
            d.timer_count[7:0] = q.timer_count[7:0] + 8'h01;
          end
          if (q.timer_count[7:0] == q.compare_latch_value[15:8]) begin
            flag_set = 1'b1;
          end
        end
      end
      default: begin
        d.run = 1'b0;
      end
    endcase

    if (!q.enable) begin
      d.run = 1'b0;
      d.fp_phase = ECT_FP_WAIT_INIT;
    end

    // Read side effects take place at the completing edge only
    if (rd) begin
      case (idx)
        `ECT_IDX_COUNT_LO: d.staging = q.timer_count[15:8];
        `ECT_IDX_CMP_LO: begin
          if (q.count_mode_field != ECT_MODE_PWM8) begin
            d.staging = q.compare_latch_value[15:8];
          end
          if (is_capture_mode(q.count_mode_field)) begin
            flag_clr = 1'b1;
          end
        end
        `ECT_IDX_CMP_HI: begin
          if (is_capture_mode(q.count_mode_field)) begin
            flag_clr = 1'b1;
          end
        end
        default: begin
          d.staging = d.staging;
        end
      endcase
    end

    // Bus writes come last so they override internal updates, except a flag clear, which a hardware set outlasts
    if (byte_wr) begin
      case (idx)
        `ECT_IDX_CTRL_A: begin
          d.enable = wbyte[`ECT_POS_ENABLE];
          d.clk_sel = wbyte[`ECT_POS_CLKSEL +: 2];
        end
        `ECT_IDX_CTRL_B: begin
          d.count_mode_field = ect_mode_t'(wbyte[`ECT_POS_MODE +: 3]);
          d.fp_phase = ECT_FP_WAIT_INIT;
        end
        `ECT_IDX_EVENT_INPUT_CONTROL: begin
          d.edge_sel = wbyte[`ECT_POS_EDGE];
          d.event_latch_input_enable = wbyte[`ECT_POS_EVLATCH_EN];
        end
        `ECT_IDX_INTEN: d.latch_ie = wbyte[`ECT_POS_LATCH_IE];
        `ECT_IDX_FLAGS: flag_clr = wbyte[`ECT_POS_LATCH_FLAG];
        `ECT_IDX_HALTCTL: d.halt_bypass = wbyte[`ECT_POS_HALT_BYPASS];
        `ECT_IDX_STAGING: d.staging = wbyte;
        `ECT_IDX_COUNT_LO: d.staging = wbyte;
        `ECT_IDX_COUNT_HI: d.timer_count = {wbyte, q.staging};
        `ECT_IDX_CMP_LO: begin
          if (q.count_mode_field == ECT_MODE_PWM8) begin
            d.compare_latch_value[7:0] = wbyte;
          end else begin
            d.staging = wbyte;
          end
        end
        `ECT_IDX_CMP_HI: begin
          if (q.count_mode_field == ECT_MODE_PWM8) begin
            d.compare_latch_value[15:8] = wbyte;
          end else begin
            d.compare_latch_value = {wbyte, q.staging};
          end
        end
        default: begin
          d.staging = d.staging; // Status is read-only
        end
      endcase
    end

    // A hardware set in the clearing cycle survives
    d.latch_flag = flag_set | (q.latch_flag & ~flag_clr);
    d.irq = d.latch_flag & d.latch_ie;

    // APB answer: one wait cycle, data captured in the first access cycle
    d.pready = setup_acc;
    d.pslverr = setup_acc & ~mapped;
    d.prdata = 8'h00;
    if (setup_acc && !PWRITE_IN && mapped) begin
      case (idx)
        `ECT_IDX_CTRL_A: d.prdata = {5'h00, q.clk_sel, q.enable};
        `ECT_IDX_CTRL_B: d.prdata = {5'h00, q.count_mode_field};
        `ECT_IDX_EVENT_INPUT_CONTROL: d.prdata = {3'h0, q.edge_sel, 3'h0, q.event_latch_input_enable};
        `ECT_IDX_INTEN: d.prdata = {7'h00, q.latch_ie};
        `ECT_IDX_FLAGS: d.prdata = {7'h00, q.latch_flag};
        `ECT_IDX_STATUS: d.prdata = {7'h00, q.run};
        `ECT_IDX_HALTCTL: d.prdata = {7'h00, q.halt_bypass};
        `ECT_IDX_STAGING: d.prdata = q.staging;
        `ECT_IDX_COUNT_LO: d.prdata = q.timer_count[7:0];
        `ECT_IDX_COUNT_HI: d.prdata = q.staging;
        `ECT_IDX_CMP_LO: d.prdata = q.compare_latch_value[7:0];
        `ECT_IDX_CMP_HI: begin
          if (q.count_mode_field == ECT_MODE_PWM8) begin
            d.prdata = q.compare_latch_value[15:8];
          end else begin
            d.prdata = q.staging;
          end
        end
        default: d.prdata = 8'h00;
      endcase
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      q.enable <= 1'b0;
      q.clk_sel <= `ECT_CLKSEL_FULL;
      q.count_mode_field <= ECT_MODE_PERIODIC;
      q.edge_sel <= 1'b0;
      q.event_latch_input_enable <= 1'b0;
      q.latch_ie <= 1'b0;
      q.latch_flag <= 1'b0;
      q.run <= 1'b0;
      q.halt_bypass <= 1'b0;
      q.staging <= `ECT_RST_BYTE;
      q.timer_count <= `ECT_RST_WORD;
      q.compare_latch_value <= `ECT_RST_WORD;
      q.ev_prev <= 1'b0;
      q.fp_phase <= ECT_FP_WAIT_INIT;
      q.div <= 1'b0;
      q.pready <= 1'b0;
      q.pslverr <= 1'b0;
      q.prdata <= `ECT_RST_BYTE;
      q.irq <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign PRDATA_OUT = {24'h000000, q.prdata};
  assign PREADY_OUT = q.pready;
  assign PSLVERR_OUT = q.pslverr;
  assign IRQ_OUT = q.irq;
  assign RUN_OUT = q.run;

endmodule

`default_nettype wire

/* test/ect_event_src.sv */
// Event routing fabric model that drives the timer event level
`timescale 1ns/1ns
`default_nettype none

module ect_event_src (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic level_in,
  output logic event_out
);
  // ========
  // Registered stage, so the timer sees a clean same-clock level
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      event_out <= 1'b0;
    end else begin
      event_out <= level_in;
    end
  end
endmodule

`default_nettype wire

/* test/ect_timer_asserts.sv */
// Port-level assertions of the event capture timer
`timescale 1ns/1ns
`default_nettype none

module ect_timer_asserts
  import ect_pkg::*;
(
  input wire logic CORE_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [3:0] PSTRB_IN,
  input wire logic EVENT_IN,
  input wire logic DBG_HALT_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  input wire logic IRQ_OUT,
  input wire logic RUN_OUT
);
  logic byp_q;
  logic bad_addr;

  // ========
  // Halt bypass copy, followed from completed writes
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      byp_q <= 1'b0;
    end else if (PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN && PSTRB_IN[0] && PADDR_IN == 8'h20) begin
      byp_q <= PWDATA_IN[0];
    end
  end
  assign bad_addr = PADDR_IN[5:2] inside {4'h2, 4'h3, 4'he, 4'hf} || PADDR_IN[7:6] != 2'h0 || PADDR_IN[1:0] != 2'h0;

  // ========
  // Properties
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  a_ready_wait: assert property (PSEL_IN && PENABLE_IN && !PREADY_OUT |=> PREADY_OUT)
    else $error("ready late");
  a_ready_pulse: assert property (PREADY_OUT |=> !PREADY_OUT)
    else $error("ready too long");
  a_idle_quiet: assert property (!(PSEL_IN && PENABLE_IN) |=> !PREADY_OUT && !PSLVERR_OUT)
    else $error("answer without access");
  a_data_zero: assert property (PRDATA_OUT[31:8] == 24'h0 && (PREADY_OUT || PRDATA_OUT == 32'h0))
    else $error("read data not zero");
  a_err_decode: assert property (PREADY_OUT |-> PSLVERR_OUT == bad_addr)
    else $error("error response wrong");
  a_err_quiet: assert property (PSLVERR_OUT |-> PREADY_OUT && PRDATA_OUT == 32'h0)
    else $error("error with data");
  a_run_status: assert property (PREADY_OUT && !PWRITE_IN && PADDR_IN == 8'h1c |-> PRDATA_OUT[0] == $past(RUN_OUT))
    else $error("status differs from run");
  a_irq_hold: assert property ($fell(IRQ_OUT) |-> $past(PSEL_IN && PENABLE_IN && PREADY_OUT))
    else $error("irq dropped by itself");
  a_halt_freeze: assert property (DBG_HALT_IN && !byp_q && !PREADY_OUT |=> $stable(RUN_OUT) && !$rose(IRQ_OUT))
    else $error("active while halted");
endmodule

bind ect_timer ect_timer_asserts chk_i (
  .CORE_CLK_IN, .RST_N_IN, .PSEL_IN, .PENABLE_IN, .PWRITE_IN, .PADDR_IN, .PWDATA_IN, .PSTRB_IN,
  .EVENT_IN, .DBG_HALT_IN, .PRDATA_OUT, .PREADY_OUT, .PSLVERR_OUT, .IRQ_OUT, .RUN_OUT
);

`default_nettype wire

/* test/tb_event_capture_timer_modes.sv */
// Self-checking bench of the event capture timer
`timescale 1ns/1ns
`default_nettype none

module tb_event_capture_timer_modes
  import ect_pkg::*;
;
  logic clk, rst_n, psel, pen, pwr, halt, lvl, ev, err_q, pready, pslverr, irq, run;
  logic [7:0] padr;
  logic [3:0] strb;
  logic [31:0] pwd, prd;
  int error_cnt, checks;
  logic [19:0] rows [7] = '{
    20'h5_01_01,
    20'h8_01_01,
    20'h8_00_00,
    20'h9_a5_a5,
    20'h7_01_00,
    20'h6_01_00,
    20'h1_07_07
  };

  ect_event_src src (.clk_in(clk), .rst_n_in(rst_n), .level_in(lvl), .event_out(ev));
  ect_timer dut (
    .CORE_CLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
    .PADDR_IN(padr), .PWDATA_IN(pwd), .PSTRB_IN(strb), .EVENT_IN(ev), .DBG_HALT_IN(halt),
    .PRDATA_OUT(prd), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .IRQ_OUT(irq), .RUN_OUT(run)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ========
  // Tasks
  task automatic complete_run();
    if (error_cnt == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [3:0] i, input logic [7:0] d, output logic [7:0] r);
    psel <= 1'b1;
    pwr <= w;
    padr <= {2'h0, i, 2'h0};
    pwd <= {24'h0, d};
    @(posedge clk);
    pen <= 1'b1;
    // No cycle count is assumed here; a missing answer is caught by the watchdog
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prd[7:0];
    err_q = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    logic [7:0] r;
    apb(1'b1, i, d, r);
  endtask

  task automatic rd(input logic [3:0] i, input logic [7:0] e);
    logic [7:0] r;
    apb(1'b0, i, 8'h00, r);
    chk({8'h00, r}, {8'h00, e});
  endtask

  task automatic ev_to(input logic l);
    lvl <= l;
    repeat (4) @(posedge clk);
  endtask

  task automatic cfg(input ect_mode_t m, input logic [7:0] evc, input logic [15:0] cnt);
    wr(4'h0, 8'h00);
    wr(4'h6, 8'h01);
    wr(4'h1, {5'h00, m});
    wr(4'h4, evc);
    wr(4'ha, cnt[7:0]);
    wr(4'hb, cnt[15:8]);
    // Clock select 2 gives no ticks, so counts only move on events
    wr(4'h0, 8'h05);
  endtask

  // ========
  // Main sequence
  initial begin
    logic [7:0] r8;
    int n;
    rst_n = 1'b0;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    padr = 8'h00;
    pwd = 32'h0;
    strb = 4'h1;
    halt = 1'b0;
    lvl = 1'b0;
    err_q = 1'b0;
    error_cnt = 0;
    checks = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 5; i < 14; i++) rd(4'(i), 8'h00);
    apb(1'b0, 4'h2, 8'h00, r8);
    chk({7'h00, err_q, r8}, 16'h0100);
    foreach (rows[k]) begin
      wr(rows[k][19:16], rows[k][15:8]);
      rd(rows[k][19:16], rows[k][7:0]);
    end
    wr(4'h9, 8'h99);
    wr(4'hd, 8'h34);
    wr(4'hc, 8'h12);
    rd(4'hd, 8'h34);
    rd(4'hc, 8'h12);
    cfg(ECT_MODE_PERIODIC, 8'h01, 16'h0000);
    wr(4'hc, 8'h05);
    wr(4'hd, 8'h00);
    rd(4'hc, 8'h05);
    rd(4'h9, 8'h00);
    ev_to(1'b1);
    ev_to(1'b0);
    chk(irq, 1'b0);
    wr(4'h0, 8'h01);
    n = 0;
    while (irq !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    chk(n inside {[5:7]}, 1'b1);
    wr(4'h0, 8'h00);
    chk(irq, 1'b1);
    wr(4'h6, 8'h01);
    chk(irq, 1'b0);
    cfg(ECT_MODE_LATCH_FLAG_EVENT, 8'h00, 16'h1234);
    ev_to(1'b1);
    ev_to(1'b0);
    chk(irq, 1'b0);
    wr(4'h4, 8'h01);
    ev_to(1'b1);
    chk(irq, 1'b1);
    rd(4'hc, 8'h34);
    chk(irq, 1'b0);
    rd(4'hd, 8'h12);
    halt <= 1'b1;
    ev_to(1'b0);
    ev_to(1'b1);
    chk(irq, 1'b0);
    wr(4'h8, 8'h01);
    ev_to(1'b0);
    ev_to(1'b1);
    chk(irq, 1'b1);
    halt <= 1'b0;
    wr(4'h8, 8'h00);
    cfg(ECT_MODE_FREQ, 8'h11, 16'h0042);
    ev_to(1'b0);
    chk(irq, 1'b1);
    rd(4'ha, 8'h00);
    rd(4'hc, 8'h42);
    ev_to(1'b1);
    chk(irq, 1'b0);
    cfg(ECT_MODE_PULSE_WIDTH, 8'h01, 16'h0077);
    ev_to(1'b0);
    chk(irq, 1'b1);
    rd(4'hc, 8'h77);
    ev_to(1'b1);
    rd(4'ha, 8'h00);
    for (int e = 0; e < 2; e++) begin
      cfg(ECT_MODE_TIMEOUT, {3'h0, e[0], 4'h1}, 16'h0000);
      ev_to(e[0]);
      ev_to(!e[0]);
      chk(run, 1'b1);
      ev_to(e[0]);
      chk(run, 1'b0);
      ev_to(1'b1);
      cfg(ECT_MODE_SINGLE_SHOT, {3'h0, e[0], 4'h1}, 16'h0000);
      ev_to(1'b0);
      chk(run, e[0]);
      ev_to(1'b1);
      chk(run, 1'b1);
      cfg(ECT_MODE_FREQ_PW, {3'h0, e[0], 4'h1}, 16'h0011);
      ev_to(e[0]);
      ev_to(!e[0]);
      rd(4'ha, 8'h00);
      wr(4'ha, 8'h22);
      wr(4'hb, 8'h00);
      ev_to(e[0]);
      chk(irq, 1'b0);
      ev_to(!e[0]);
      chk(irq, 1'b1);
      rd(4'hc, 8'h22);
    end
    // PWM: low byte wraps at compare low, flag when it equals compare high
    cfg(ECT_MODE_PWM8, 8'h01, 16'h0000);
    wr(4'hc, 8'h03);
    wr(4'hd, 8'h02);
    wr(4'h0, 8'h01);
    @(posedge clk);
    chk(irq, 1'b0);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1);
    wr(4'h0, 8'h00);
    rd(4'ha, 8'h03);
    rd(4'hb, 8'h00);
    // Single shot with real ticks: stops and flags at TOP
    cfg(ECT_MODE_SINGLE_SHOT, 8'h01, 16'h0000);
    wr(4'hc, 8'h03);
    wr(4'hd, 8'h00);
    wr(4'h0, 8'h01);
    ev_to(1'b1);
    chk(run, 1'b1);
    chk(irq, 1'b0);
    repeat (3) @(posedge clk);
    chk(irq, 1'b1);
    chk(run, 1'b0);
    // A count write lands even though the counter ticks in that cycle
    cfg(ECT_MODE_PERIODIC, 8'h01, 16'h0000);
    wr(4'hc, 8'hff);
    wr(4'hd, 8'hff);
    wr(4'h0, 8'h01);
    wr(4'ha, 8'h00);
    wr(4'hb, 8'h80);
    rd(4'ha, 8'h02);
    rd(4'hb, 8'h80);
    // Write with the low byte lane off must leave the staging byte alone
    strb <= 4'h0;
    wr(4'h9, 8'h5a);
    strb <= 4'h1;
    rd(4'h9, 8'h80);
    complete_run();
  end

  // ========
  // Watchdog: the sequence needs well under 2000 cycles
  initial begin
    #40000;
    error_cnt++;
    complete_run();
  end
endmodule

`default_nettype wire
